// file: core/ctst_core.sv
// Charge termination, top-off timer and safety timers with Avalon slave
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`default_nettype none
module ctst_core
  import ctst_pkg::*;
#(
  parameter int TICK_CYC = ctst_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Charge-disable pin, active low enable
  input  wire logic        CHG_DISABLE_PIN_I,
  // Sequencer and regulation loop status
  input  wire logic [2:0]  STAGE_I,
  input  wire logic        VBAT_ABOVE_RECHG_I,
  input  wire logic        CV_LOOP_I,
  input  wire logic        IBAT_BELOW_TERM_I,
  input  wire logic        INPUT_CURRENT_LIMITING_I,
  input  wire logic        INPUT_VOLTAGE_LIMITING_I,
  input  wire logic        THERMAL_REGULATION_I,
  input  wire logic        CHG_FAULT_I,
  input  wire logic        SUPPLEMENT_I,
  input  wire logic        RECHARGE_I,
  // Outputs to power stage and host
  output logic             BATTERY_SWITCH_O,
  output logic [2:0]       CHARGE_PHASE_CODE_O,
  output logic             FAST_TIMER_EXPIRED_FLAG_O,
  output logic             ALERT_O
);
  import ctst_pkg::*;

  localparam int TW = $clog2(TICK_CYC + 1);

  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic              ack_q, ack_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [1:0]        pin_q;
  logic [TW-1:0]     pre_q, pre_d;
  logic              tick_q, tick_d, odd_q, odd_d;
  logic              half_q, half_d;
  logic              en_q;
  logic [2:0]        stage_q;
  ctst_state_t       st_q, st_d;
  logic [CNT_W-1:0]  top_q, top_d, toplim_q, toplim_d;
  logic [2:0]        phase_q, phase_d;
  logic              alert_q, alert_d;
  logic [2:0]        exp_q, exp_d;
  logic [CNT_W-1:0]  cnt_q [3];
  logic [CNT_W-1:0]  lim [3];
  logic [2:0]        tmr_clr, tmr_run;
  logic              wr_ok, dflt, chg_en, restart, regul, freeze, gate;
  logic              term_ok, top_hit;
  logic [CNT_W-1:0]  fast_lim, pre_lim, top_sel_lim;
  logic [1:0]        cls_now, cls_old;

  // Bus: one wait state, then the access completes
  assign wr_ok = AVS_WRITE_I && ack_q;
  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_q;
  assign AVS_READDATA_O = rdata_q;
  assign dflt = wr_ok && AVS_ADDRESS_I == CTST_CTRL_OFS
                && AVS_BYTEENABLE_I[1] && AVS_WRITEDATA_I[CTRL_DEFAULT_BIT];

  // Register file next state; unmapped reads return zero
  always_comb begin
    ack_d   = (AVS_READ_I || AVS_WRITE_I) && !ack_q;
    ctrl_d  = ctrl_q;
    rdata_d = rdata_q;
    if (dflt) begin
      ctrl_d = CTRL_RST;
    end else if (wr_ok && AVS_ADDRESS_I == CTST_CTRL_OFS) begin
      if (AVS_BYTEENABLE_I[0]) begin
        ctrl_d[7:0] = AVS_WRITEDATA_I[7:0];
      end
      if (AVS_BYTEENABLE_I[1]) begin
        ctrl_d[CTRL_W-1:8] = AVS_WRITEDATA_I[CTRL_W-1:8];
      end
    end
    if (AVS_READ_I && !ack_q) begin
      case (AVS_ADDRESS_I)
        CTST_CTRL_OFS:   rdata_d = {20'h0, ctrl_q};
        CTST_STATUS_OFS: rdata_d = {24'h0, half_q, BATTERY_SWITCH_O,
                                    exp_q, phase_q};
        default:         rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ack_q   <= 1'b0;
      ctrl_q  <= CTRL_RST;
      rdata_q <= 32'h0;
    end else begin
      ack_q   <= ack_d;
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // Pin synchroniser; charge enable needs the allow bit set and the pin low
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pin_q   <= 2'b11;
      en_q    <= 1'b0;
      stage_q <= PH_NONE;
    end else begin
      pin_q   <= {pin_q[0], CHG_DISABLE_PIN_I};
      en_q    <= chg_en;
      stage_q <= STAGE_I;
    end
  end
  assign chg_en  = ctrl_q[CTRL_ALLOW_BIT] && !pin_q[1];
  // Restart: enable rising, or recharge once the cycle has finished
  assign restart = (chg_en && !en_q)
                   || (RECHARGE_I && st_q == CTST_DONE);
  assign regul   = INPUT_CURRENT_LIMITING_I || INPUT_VOLTAGE_LIMITING_I
                   || THERMAL_REGULATION_I;
  assign freeze  = CHG_FAULT_I || SUPPLEMENT_I;

  // Prescaler and half-rate latch; latch persists until regulation ends
  always_comb begin
    tick_d = (pre_q == TW'(TICK_CYC - 1));
    pre_d  = tick_d ? '0 : pre_q + TW'(1);
    odd_d  = tick_q ? !odd_q : odd_q;
    half_d = regul && (half_q || ctrl_q[CTRL_HALF_EN_BIT]);
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pre_q  <= '0;
      tick_q <= 1'b0;
      odd_q  <= 1'b0;
      half_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      tick_q <= tick_d;
      odd_q  <= odd_d;
      half_q <= half_d;
    end
  end
  // Shared count gate; half rate takes every second tick only
  assign gate = tick_q && !freeze && (!half_q || odd_q);

  // Stage classes: 0 none, 1 trickle, 2 pre, 3 fast or taper
  function automatic logic [1:0] cls(input logic [2:0] s);
    case (s)
      PH_TRICK: cls = 2'd1;
      PH_PRE:   cls = 2'd2;
      PH_FAST,
      PH_TAPER: cls = 2'd3;
      default:  cls = 2'd0;
    endcase
  endfunction
  assign cls_now = cls(STAGE_I);
  assign cls_old = cls(stage_q);

  // Duration decode
  always_comb begin
    case (ctrl_q[CTRL_FAST_LSB +: 2])
      2'h0:    fast_lim = CNT_W'(FAST0_MIN * TICKS_PER_MIN);
      2'h1:    fast_lim = CNT_W'(FAST1_MIN * TICKS_PER_MIN);
      2'h2:    fast_lim = CNT_W'(FAST2_MIN * TICKS_PER_MIN);
      default: fast_lim = CNT_W'(FAST3_MIN * TICKS_PER_MIN);
    endcase
    pre_lim = ctrl_q[CTRL_PRE_SEL_BIT]
            ? CNT_W'(PRE_SHORT_MIN * TICKS_PER_MIN)
            : CNT_W'(PRE_LONG_MIN * TICKS_PER_MIN);
    case (ctrl_q[CTRL_TOP_LSB +: 2])
      2'h1:    top_sel_lim = CNT_W'(TOP1_MIN * TICKS_PER_MIN);
      2'h2:    top_sel_lim = CNT_W'(TOP2_MIN * TICKS_PER_MIN);
      2'h3:    top_sel_lim = CNT_W'(TOP3_MIN * TICKS_PER_MIN);
      default: top_sel_lim = '0;
    endcase
  end
  assign lim[0] = CNT_W'(TRICKLE_MIN * TICKS_PER_MIN);
  assign lim[1] = pre_lim;
  assign lim[2] = fast_lim;

  // Per-timer clear events
  assign tmr_clr[0] = (cls_now != cls_old)
                      && (cls_now == 2'd1 || cls_old == 2'd1);
  assign tmr_clr[1] = (cls_now != cls_old)
                      && (cls_now == 2'd2 || cls_old == 2'd2)
                      || ctrl_d[CTRL_PRE_SEL_BIT] != ctrl_q[CTRL_PRE_SEL_BIT];
  assign tmr_clr[2] = (cls_now != cls_old)
                      && ((cls_now == 2'd2 && cls_old == 2'd3)
                       || (cls_now == 2'd3 && cls_old == 2'd2))
                      || ctrl_d[CTRL_FAST_LSB +: 2]
                         != ctrl_q[CTRL_FAST_LSB +: 2];

  // Safety timers, one per stage class; fast and taper share the third
  for (genvar i = 0; i < 3; i++) begin : g_tmr
    logic             en_bit, en_rise, hit;
    logic [CNT_W-1:0] cnt_d;
    assign en_bit  = ctrl_q[CTRL_TMR_EN_LSB + i];
    assign en_rise = ctrl_d[CTRL_TMR_EN_LSB + i] && !en_bit;
    // Runs only in its own stage, from the stage's first cycle
    assign tmr_run[i] = st_q == CTST_CHARGE && cls_now == 2'(i + 1)
                        && en_bit;
    assign hit = tmr_run[i] && gate && cnt_q[i] == lim[i] - CNT_W'(1);
    always_comb begin
      cnt_d   = cnt_q[i];
      exp_d[i] = exp_q[i];
      if (hit) begin
        exp_d[i] = 1'b1;
      end else if (restart) begin
        exp_d[i] = 1'b0;
      end
      if (restart || en_rise || tmr_clr[i] || !en_bit) begin
        cnt_d = '0;
      end else if (tmr_run[i] && gate && !exp_q[i]) begin
        cnt_d = cnt_q[i] + CNT_W'(1);
      end
    end
    always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
        cnt_q[i] <= '0;
        exp_q[i] <= 1'b0;
      end else begin
        cnt_q[i] <= cnt_d;
        exp_q[i] <= exp_d[i];
      end
    end
  end

  // Termination test; enable bit is only looked at while charging
  assign term_ok = VBAT_ABOVE_RECHG_I && CV_LOOP_I && IBAT_BELOW_TERM_I
                   && !regul
                   && ctrl_q[CTRL_TERM_EN_BIT];
  assign top_hit = gate && top_q == toplim_q - CNT_W'(1);

  // Cycle state, top-off count and phase code
  always_comb begin
    st_d     = st_q;
    top_d    = top_q;
    toplim_d = toplim_q;
    case (st_q)
      CTST_IDLE: begin
        if (chg_en) begin
          st_d = CTST_CHARGE;
        end
      end
      CTST_CHARGE: begin
        if (term_ok) begin
          top_d    = '0;
          toplim_d = top_sel_lim;
          st_d = (top_sel_lim != '0) ? CTST_TOPOFF : CTST_DONE;
        end
      end
      CTST_TOPOFF: begin
        if (top_hit) begin
          st_d = CTST_DONE;
        end else if (gate) begin
          top_d = top_q + CNT_W'(1);
        end
      end
      CTST_DONE: begin
        st_d = CTST_DONE;
      end
      default: begin
        st_d = CTST_IDLE;
      end
    endcase
    if (restart) begin
      st_d  = CTST_CHARGE;
      top_d = '0;
    end
    if (dflt) begin
      top_d = '0;
      if (st_q == CTST_TOPOFF) begin
        st_d = CTST_DONE;
      end
    end
    if (!chg_en) begin
      st_d = CTST_IDLE;
    end
    case (st_d)
      CTST_CHARGE: phase_d = (cls_now == 2'd0) ? PH_NONE : STAGE_I;
      CTST_TOPOFF: phase_d = PH_TOPOFF;
      CTST_DONE:   phase_d = PH_DONE;
      default:     phase_d = PH_NONE;
    endcase
    // Every phase change alerts unless masked; fast timer expiry always alerts
    alert_d = ((phase_d != phase_q) && !ctrl_q[CTRL_MASK_BIT])
              || (exp_d[2] && !exp_q[2]);
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      st_q     <= CTST_IDLE;
      top_q    <= '0;
      toplim_q <= '0;
      phase_q  <= PH_NONE;
      alert_q  <= 1'b0;
    end else begin
      st_q     <= st_d;
      top_q    <= top_d;
      toplim_q <= toplim_d;
      phase_q  <= phase_d;
      alert_q  <= alert_d;
    end
  end

  // Outputs; switch stays on through top-off, supplement overrides done
  assign BATTERY_SWITCH_O = st_q != CTST_DONE || SUPPLEMENT_I;
  assign CHARGE_PHASE_CODE_O       = phase_q;
  assign FAST_TIMER_EXPIRED_FLAG_O = exp_q[2];
  assign ALERT_O                   = alert_q;

  // Checks
  sequence s_term;
    st_q == CTST_CHARGE && term_ok && !restart && chg_en && !dflt;
  endsequence
  property p_term_done;
    @(posedge CLK_I) disable iff (SRST_I)
    (s_term and toplim_d == '0) ##1 (!restart && chg_en) |->
      ##1 (phase_q == PH_DONE && BATTERY_SWITCH_O == SUPPLEMENT_I);
  endproperty
  a_term_done: assert property (p_term_done)
    else $error("termination did not reach done");
  property p_regul_block;
    @(posedge CLK_I) disable iff (SRST_I)
    st_q == CTST_CHARGE && regul && !restart && chg_en |=>
      st_q == CTST_CHARGE;
  endproperty
  a_regul_block: assert property (p_regul_block)
    else $error("terminated during regulation");
  property p_alert_done;
    @(posedge CLK_I) disable iff (SRST_I)
    !ctrl_q[CTRL_MASK_BIT] && phase_d == PH_DONE && phase_q != PH_DONE
      |=> ALERT_O ##1 !ALERT_O || $changed(phase_q);
  endproperty
  a_alert_done: assert property (p_alert_done)
    else $error("missing alert on done");
  property p_mask;
    @(posedge CLK_I) disable iff (SRST_I)
    ctrl_q[CTRL_MASK_BIT] && !(exp_d[2] && !exp_q[2]) |=> !ALERT_O;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked alert fired");
  property p_topoff_code;
    @(posedge CLK_I) disable iff (SRST_I)
    st_q == CTST_TOPOFF |-> phase_q == PH_TOPOFF && BATTERY_SWITCH_O;
  endproperty
  a_topoff_code: assert property (p_topoff_code)
    else $error("top-off code or switch wrong");
  property p_freeze;
    @(posedge CLK_I) disable iff (SRST_I)
    st_q == CTST_TOPOFF && freeze && !restart && !dflt && chg_en
      |=> $stable(top_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("top-off counted while frozen");
  property p_half_hold;
    @(posedge CLK_I) disable iff (SRST_I)
    half_q && regul |=> half_q;
  endproperty
  a_half_hold: assert property (p_half_hold)
    else $error("half rate dropped during regulation");
  property p_restart;
    @(posedge CLK_I) disable iff (SRST_I)
    restart |=> cnt_q[0] == '0 && cnt_q[1] == '0 && cnt_q[2] == '0
                && top_q == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("timers not cleared on restart");
  property p_fast_flag;
    @(posedge CLK_I) disable iff (SRST_I)
    $rose(FAST_TIMER_EXPIRED_FLAG_O) |-> ALERT_O;
  endproperty
  a_fast_flag: assert property (p_fast_flag)
    else $error("fast expiry without alert");
endmodule
`default_nettype wire

// file: pkg/ctst_pkg.sv
// Constants for the charge termination and safety timer block
`default_nettype none
package ctst_pkg;
  // Register byte offsets
  localparam logic [3:0] CTST_CTRL_OFS    = 4'h0;
  localparam logic [3:0] CTST_STATUS_OFS  = 4'h4;
  // Control register fields
  localparam int CTRL_ALLOW_BIT   = 0;
  localparam int CTRL_TERM_EN_BIT = 1;
  localparam int CTRL_HALF_EN_BIT = 2;
  localparam int CTRL_TMR_EN_LSB  = 3;   // Trickle, pre, fast: bits 3..5
  localparam int CTRL_PRE_SEL_BIT = 6;
  localparam int CTRL_FAST_LSB    = 7;   // Two bits
  localparam int CTRL_TOP_LSB     = 9;   // Two bits
  localparam int CTRL_MASK_BIT    = 11;
  localparam int CTRL_DEFAULT_BIT = 12;  // Write-one, self clearing
  localparam int CTRL_W           = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h13f;
  // Status register fields
  localparam int STAT_PHASE_LSB   = 0;   // Three bits
  localparam int STAT_EXP_LSB     = 3;   // Trickle, pre, fast: bits 3..5
  localparam int STAT_SWITCH_BIT  = 6;
  localparam int STAT_HALF_BIT    = 7;
  // Charge phase codes
  localparam logic [2:0] PH_NONE   = 3'h0;
  localparam logic [2:0] PH_TRICK  = 3'h1;
  localparam logic [2:0] PH_PRE    = 3'h2;
  localparam logic [2:0] PH_FAST   = 3'h3;
  localparam logic [2:0] PH_TAPER  = 3'h4;
  localparam logic [2:0] PH_TOPOFF = 3'h6;
  localparam logic [2:0] PH_DONE   = 3'h7;
  // Timing: clock rate and slow tick period
  localparam int CLK_HZ        = 20_000_000;
  localparam int TICK_MS       = 1000;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_MIN = 60 * 1000 / TICK_MS;
  // Timer durations in minutes
  localparam int TRICKLE_MIN   = 60;
  localparam int PRE_LONG_MIN  = 120;
  localparam int PRE_SHORT_MIN = 30;
  localparam int FAST0_MIN     = 300;
  localparam int FAST1_MIN     = 480;
  localparam int FAST2_MIN     = 720;
  localparam int FAST3_MIN     = 1440;
  localparam int TOP1_MIN      = 15;
  localparam int TOP2_MIN      = 30;
  localparam int TOP3_MIN      = 45;
  localparam int CNT_W         = 17;
  // Cycle state
  typedef enum logic [1:0] {
    CTST_IDLE, CTST_CHARGE, CTST_TOPOFF, CTST_DONE
  } ctst_state_t;
endpackage
`default_nettype wire

// file: verif/charge_termination_safety_timer_tb.sv
// Self-checking bench for the charge termination and safety timer block
`default_nettype none
module charge_termination_safety_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ctst_pkg::*;
  // Bench-driven signals
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic        pin = 1'b0;
  logic [2:0]  stage_cmd = 3'h0;
  logic [8:0]  flag_cmd = 9'h000;
  // Observed signals
  logic [2:0]  stage;
  logic [8:0]  flag;
  logic [31:0] rdat;
  logic        waitreq;
  logic        bsw;
  logic        fexp;
  logic        alert;
  logic [2:0]  phase;
  logic [31:0] rv;
  int          miscompares = 0;
  int          n_compared = 0;
  int          alerts = 0;
  int          a0;

  // Flag order: vbat, cv, low current, icl, ivl, thermal, fault, supp, rechg
  ctst_seq_model i_ctst_seq_model (
    .clk_i       (clk),
    .stage_cmd_i (stage_cmd),
    .flag_cmd_i  (flag_cmd),
    .stage_o     (stage),
    .flag_o      (flag)
  );

  // Short tick keeps hour-long timers within the run
  ctst_core #(.TICK_CYC(4)) i_ctst_core (
    .CLK_I                     (clk),
    .SRST_I                    (srst),
    .AVS_ADDRESS_I             (adr),
    .AVS_READ_I                (rd),
    .AVS_WRITE_I               (wr),
    .AVS_WRITEDATA_I           (wdat),
    .AVS_BYTEENABLE_I          (4'hf),
    .AVS_READDATA_O            (rdat),
    .AVS_WAITREQUEST_O         (waitreq),
    .CHG_DISABLE_PIN_I         (pin),
    .STAGE_I                   (stage),
    .VBAT_ABOVE_RECHG_I        (flag[0]),
    .CV_LOOP_I                 (flag[1]),
    .IBAT_BELOW_TERM_I         (flag[2]),
    .INPUT_CURRENT_LIMITING_I  (flag[3]),
    .INPUT_VOLTAGE_LIMITING_I  (flag[4]),
    .THERMAL_REGULATION_I      (flag[5]),
    .CHG_FAULT_I               (flag[6]),
    .SUPPLEMENT_I              (flag[7]),
    .RECHARGE_I                (flag[8]),
    .BATTERY_SWITCH_O          (bsw),
    .CHARGE_PHASE_CODE_O       (phase),
    .FAST_TIMER_EXPIRED_FLAG_O (fexp),
    .ALERT_O                   (alert)
  );

  // Clock at 50 ns period
  always #25 clk = ~clk;

  // Alert pulses are one cycle wide, so count them per edge
  always @(posedge clk) begin
    if (alert === 1'b1) begin
      alerts <= alerts + 1;
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic pchk(input logic [2:0] e);
    chk({29'h0, phase}, {29'h0, e});
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One Avalon transfer; held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr  <= a;
    wdat <= d;
    wr   <= w;
    rd   <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    rv = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      $display("BAD %0t: bus never answered", $time);
      finish_test();
    end
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv & m, e);
  endtask

  // Sequencer command; partner plus block add two edges of latency
  task automatic drive(input logic [2:0] s, input logic [8:0] f);
    @(posedge clk);
    stage_cmd <= s;
    flag_cmd  <= f;
    repeat (4) @(posedge clk);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    // Defaults and unmapped space
    rchk(CTST_CTRL_OFS, 32'hfff, 32'h13f);
    rchk(CTST_STATUS_OFS, 32'h7f, 32'h40);
    bus(1'b1, 4'h8, 32'hfff);
    rchk(4'h8, 32'hffffffff, 32'h0);
    rchk(CTST_CTRL_OFS, 32'hfff, 32'h13f);
    chk({31'h0, fexp}, 32'h0);
    $display("test defaults ended");
    // Trickle stage and its fixed one hour timer
    drive(PH_TRICK, 9'h000);
    pchk(PH_TRICK);
    repeat (14300) @(posedge clk);
    rchk(CTST_STATUS_OFS, 32'h08, 32'h00);
    repeat (200) @(posedge clk);
    rchk(CTST_STATUS_OFS, 32'h0f, 32'h09);
    $display("test trickle timer ended");
    // Short pre-charge timer at half rate; half enable dropped right after the stage starts
    bus(1'b1, CTST_CTRL_OFS, 32'h17f);
    drive(PH_PRE, 9'h008);
    bus(1'b1, CTST_CTRL_OFS, 32'h17b);
    rchk(CTST_STATUS_OFS, 32'h87, 32'h82);
    repeat (10000) @(posedge clk);
    rchk(CTST_STATUS_OFS, 32'h10, 32'h00);
    repeat (4600) @(posedge clk);
    rchk(CTST_STATUS_OFS, 32'h10, 32'h10);
    $display("test half rate ended");
    // Later stages and regulation holding off termination
    drive(PH_FAST, 9'h000);
    pchk(PH_FAST);
    for (int i = 3; i < 6; i++) begin
      drive(PH_TAPER, 9'h007 | (9'h001 << i));
      pchk(PH_TAPER);
      chk({31'h0, bsw}, 32'h1);
    end
    a0 = alerts;
    drive(PH_TAPER, 9'h007);
    pchk(PH_DONE);
    chk({31'h0, bsw}, 32'h0);
    chk(alerts - a0, 1);
    drive(PH_TAPER, 9'h087);
    chk({31'h0, bsw}, 32'h1);
    drive(PH_TAPER, 9'h007);
    $display("test termination ended");
    // Term enable cleared in done, top-off armed, then recharge restart
    bus(1'b1, CTST_CTRL_OFS, 32'h33d);
    pchk(PH_DONE);
    drive(PH_TAPER, 9'h100);
    drive(PH_TAPER, 9'h000);
    drive(PH_TAPER, 9'h007);
    pchk(PH_TAPER);
    a0 = alerts;
    bus(1'b1, CTST_CTRL_OFS, 32'h33f);
    repeat (3) @(posedge clk);
    pchk(PH_TOPOFF);
    chk({31'h0, bsw}, 32'h1);
    // Longer duration and term disable while topping off both ignored
    bus(1'b1, CTST_CTRL_OFS, 32'h73d);
    // Supplement briefly freezes the top-off count, code and switch hold
    drive(PH_TAPER, 9'h087);
    pchk(PH_TOPOFF);
    chk({31'h0, bsw}, 32'h1);
    drive(PH_TAPER, 9'h007);
    repeat (3400) @(posedge clk);
    pchk(PH_TOPOFF);
    repeat (300) @(posedge clk);
    pchk(PH_DONE);
    chk(alerts - a0, 2);
    $display("test top-off ended");
    // Mask hides every cycle alert, top-off start included
    bus(1'b1, CTST_CTRL_OFS, 32'hb3f);
    a0 = alerts;
    drive(PH_TAPER, 9'h100);
    drive(PH_TAPER, 9'h000);
    drive(PH_TAPER, 9'h007);
    pchk(PH_TOPOFF);
    chk(alerts - a0, 0);
    // Defaults reset in top-off restores control and ends top-off
    bus(1'b1, CTST_CTRL_OFS, 32'h1000);
    rchk(CTST_CTRL_OFS, 32'hfff, 32'h13f);
    pchk(PH_DONE);
    // Pin disable ends the cycle; synchroniser adds two edges
    @(posedge clk);
    pin <= 1'b1;
    repeat (6) @(posedge clk);
    pchk(PH_NONE);
    pin <= 1'b0;
    $display("test mask and pin ended");
    finish_test();
  end
endmodule
`default_nettype wire

// file: verif/ctst_seq_model.sv
// Behavioural charger sequencer and regulation loops feeding the block
`default_nettype none
module ctst_seq_model (
  // Clock
  input  wire logic       clk_i,
  // Commands from the bench
  input  wire logic [2:0] stage_cmd_i,
  input  wire logic [8:0] flag_cmd_i,
  // Status towards the block
  output var logic [2:0]  stage_o = 3'h0,
  output var logic [8:0]  flag_o = 9'h000
);
  timeunit 1ns;
  timeprecision 1ns;
  // Loop flags settle one clock after the bench asks, as real loops lag
  always @(posedge clk_i) begin
    stage_o <= stage_cmd_i;
    flag_o  <= flag_cmd_i;
  end
endmodule
`default_nettype wire
